// ==== shared/asb_cfg.svh ====
// constants of the converter sequence control block: offsets, fields, resets
// assumes inclusion by bare name from the control block and the bench
`ifndef ASB_CFG_SVH
`define ASB_CFG_SVH

`define ASB_ADDR_W 4
`define ASB_CTRL_OFFSET 4'h0
`define ASB_CTRL_RESET 16'h0000
`define ASB_CTRL_WMASK 16'he73f
`define ASB_REF_MSB 15
`define ASB_REF_LSB 13
`define ASB_SCAN_BIT 10
`define ASB_COUNT_MSB 9
`define ASB_COUNT_LSB 8
`define ASB_HALF_BIT 7
`define ASB_RATE_MSB 5
`define ASB_RATE_LSB 2
`define ASB_SPLIT_BIT 1
`define ASB_ALT_BIT 0
`define ASB_FIFO_DEPTH 16
`define ASB_HALF_SIZE 3'h7

`endif

// ==== shared/asb_pkg.sv ====
// types shared by the converter sequence control block
// assumes asb_cfg.svh holds the numeric constants
`default_nettype none
package asb_pkg;
    typedef enum logic {ASB_REF_ANALOGUE_SUPPLY, ASB_REF_ANALOGUE_GROUND} asb_ref_t;
    typedef enum {ASB_IDLE, ASB_REQ, ASB_WAIT, ASB_PUSH} asb_state_t;
endpackage : asb_pkg
`default_nettype wire

// ==== rtl/asb_fifo.sv ====
// result fifo with valid/ready on both sides
// assumes one clock, asynchronous active-low reset
`default_nettype none
module asb_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;
    logic [WIDTH-1:0] head_r, head_nxt;

    // honest full and empty from the occupancy count
    assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o = head_r;
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // pointer and count next values
    always_comb begin
        wptr_nxt = push ? AW'(wptr_r + 1'b1) : wptr_r;
        rptr_nxt = pop ? AW'(rptr_r + 1'b1) : rptr_r;
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = (AW+1)'(cnt_r + 1'b1);
        end else if (pop && !push) begin
            cnt_nxt = (AW+1)'(cnt_r - 1'b1);
        end
        // head word comes out of a register; a word pushed straight into the head slot
        // bypasses the array, which is only written at this same edge
        if (push && (wptr_r == rptr_nxt)) begin
            head_nxt = in_data_i;
        end else begin
            head_nxt = mem_r[rptr_nxt];
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r <= '0;
            head_r <= '0;
        end else begin
            wptr_r <= wptr_nxt;
            rptr_r <= rptr_nxt;
            cnt_r <= cnt_nxt;
            head_r <= head_nxt;
        end
    end

    // storage has no reset: contents are only read once counted valid
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wptr_r] <= in_data_i;
        end
    end
endmodule : asb_fifo
`default_nettype wire

// ==== rtl/asb_seq_ctrl.sv ====
// converter sequence control register and the sequencing logic it steers
// assumes converter handshake, trigger and input selections on clk_i
`include "asb_cfg.svh"
`default_nettype none
module asb_seq_ctrl (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [15:0] reg_rdata_o,
    input wire logic trig_i,
    input wire logic [15:0] scan_mask_i,
    input wire logic [3:0] sample_a_ch_i,
    input wire logic [3:0] sample_b_ch_i,
    output asb_pkg::asb_ref_t positive_reference_o,
    output asb_pkg::asb_ref_t negative_reference_o,
    output logic conv_req_o,
    output logic [1:0] conv_ch_o,
    output logic [3:0] chan_zero_sel_o,
    output logic use_sample_b_o,
    input wire logic conv_done_i,
    input wire logic [9:0] conv_data_i,
    output logic conv_irq_o,
    output logic res_valid_o,
    input wire logic res_ready_i,
    output logic [15:0] res_data_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    ////////////////////////////////////////////////////////////////////////////
    // register file
    logic [15:0] ctrl_r, ctrl_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic half_r, half_nxt;
    logic sel_ctrl;
    logic scan_en, split_en, alt_en;
    logic [1:0] count_sel;
    logic [3:0] rate_sel;

    assign sel_ctrl = (reg_addr_i == `ASB_CTRL_OFFSET);
    assign scan_en = ctrl_r[`ASB_SCAN_BIT];
    assign count_sel = ctrl_r[`ASB_COUNT_MSB:`ASB_COUNT_LSB];
    assign rate_sel = ctrl_r[`ASB_RATE_MSB:`ASB_RATE_LSB];
    assign split_en = ctrl_r[`ASB_SPLIT_BIT];
    assign alt_en = ctrl_r[`ASB_ALT_BIT];

    // writes keep only implemented read/write bits; status is merged on read
    always_comb begin
        ctrl_nxt = ctrl_r;
        rdata_nxt = 16'h0000;
        if (reg_we_i && sel_ctrl) begin
            ctrl_nxt = reg_wdata_i & `ASB_CTRL_WMASK;
        end
        if (reg_re_i && sel_ctrl) begin
            rdata_nxt = ctrl_r;
            rdata_nxt[`ASB_HALF_BIT] = half_r;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_r <= `ASB_CTRL_RESET;
            rdata_r <= 16'h0000;
        end else begin
            ctrl_r <= ctrl_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;

    // the reference field is stored but only one source pair exists
    assign positive_reference_o = asb_pkg::ASB_REF_ANALOGUE_SUPPLY;
    assign negative_reference_o = asb_pkg::ASB_REF_ANALOGUE_GROUND;

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    asb_pkg::asb_state_t state_r, state_nxt;
    logic [1:0] ch_r, ch_nxt;
    logic [1:0] last_ch;
    logic [9:0] data_r, data_nxt;
    logic [3:0] seq_cnt_r, seq_cnt_nxt;
    logic [3:0] idx_r, idx_nxt;
    logic [3:0] scan_ptr_r, scan_ptr_nxt;
    logic alt_r, alt_nxt;
    logic irq_r, irq_nxt;
    logic seq_end;
    logic fifo_in_ready;

    // 1x selects all four channels
    always_comb begin
        case (count_sel)
            2'h0: last_ch = 2'h0;
            2'h1: last_ch = 2'h1;
            default: last_ch = 2'h3;
        endcase
    end

    // next selected scan input after ptr, wrapping; stays put if none set
    function automatic logic [3:0] next_scan(input logic [3:0] ptr, input logic [15:0] mask);
        logic [3:0] r;
        logic [3:0] k;
        r = ptr;
        for (int i = 16; i >= 1; i--) begin
            k = 4'(ptr + 5'(i));
            if (mask[k]) begin
                r = k;
            end
        end
        return r;
    endfunction : next_scan

    assign seq_end = (state_r == asb_pkg::ASB_PUSH) && fifo_in_ready && (ch_r == last_ch);

    // one sequence: request each channel, wait its result, push it
    always_comb begin
        state_nxt = state_r;
        ch_nxt = ch_r;
        data_nxt = data_r;
        seq_cnt_nxt = seq_cnt_r;
        idx_nxt = idx_r;
        half_nxt = split_en ? half_r : 1'b0;
        scan_ptr_nxt = scan_ptr_r;
        alt_nxt = alt_en ? alt_r : 1'b0;
        irq_nxt = 1'b0;
        case (state_r)
            asb_pkg::ASB_IDLE: begin
                if (trig_i) begin
                    state_nxt = asb_pkg::ASB_REQ;
                    ch_nxt = 2'h0;
                end
            end
            asb_pkg::ASB_REQ: begin
                state_nxt = asb_pkg::ASB_WAIT;
            end
            asb_pkg::ASB_WAIT: begin
                if (conv_done_i) begin
                    data_nxt = conv_data_i;
                    state_nxt = asb_pkg::ASB_PUSH;
                end
            end
            asb_pkg::ASB_PUSH: begin
                // a full fifo holds the sequencer here, so no result is lost
                if (fifo_in_ready) begin
                    if (split_en) begin
                        idx_nxt = {half_r, 3'(idx_r[2:0] + 1'b1)};
                    end else begin
                        idx_nxt = 4'(idx_r + 1'b1);
                    end
                    if (ch_r == last_ch) begin
                        state_nxt = asb_pkg::ASB_IDLE;
                        alt_nxt = alt_en && !alt_r;
                        if (scan_en) begin
                            scan_ptr_nxt = next_scan(scan_ptr_r, scan_mask_i);
                        end
                        if (seq_cnt_r == rate_sel) begin
                            irq_nxt = 1'b1;
                            seq_cnt_nxt = 4'h0;
                            half_nxt = split_en && !half_r;
                            idx_nxt = {split_en && !half_r, 3'h0};
                        end else begin
                            seq_cnt_nxt = 4'(seq_cnt_r + 1'b1);
                        end
                    end else begin
                        ch_nxt = 2'(ch_r + 1'b1);
                        state_nxt = asb_pkg::ASB_REQ;
                    end
                end
            end
            default: begin
                state_nxt = asb_pkg::ASB_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= asb_pkg::ASB_IDLE;
            ch_r <= 2'h0;
            data_r <= 10'h000;
            seq_cnt_r <= 4'h0;
            idx_r <= 4'h0;
            half_r <= 1'b0;
            scan_ptr_r <= 4'h0;
            alt_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ch_r <= ch_nxt;
            data_r <= data_nxt;
            seq_cnt_r <= seq_cnt_nxt;
            idx_r <= idx_nxt;
            half_r <= half_nxt;
            scan_ptr_r <= scan_ptr_nxt;
            alt_r <= alt_nxt;
            irq_r <= irq_nxt;
        end
    end

    // converter request and input selection; scanning only touches sample A
    assign conv_req_o = (state_r == asb_pkg::ASB_REQ);
    assign conv_ch_o = ch_r;
    assign use_sample_b_o = alt_en && alt_r;
    always_comb begin
        if (use_sample_b_o) begin
            chan_zero_sel_o = sample_b_ch_i;
        end else if (scan_en) begin
            chan_zero_sel_o = scan_ptr_r;
        end else begin
            chan_zero_sel_o = sample_a_ch_i;
        end
    end
    assign conv_irq_o = irq_r;

    ////////////////////////////////////////////////////////////////////////////
    // result buffer: word is fill index, channel, result
    asb_fifo #(
        .WIDTH(16),
        .DEPTH(`ASB_FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(state_r == asb_pkg::ASB_PUSH),
        .in_ready_o(fifo_in_ready),
        .in_data_i({idx_r, ch_r, data_r}),
        .out_valid_o(res_valid_o),
        .out_ready_i(res_ready_i),
        .out_data_o(res_data_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_req_wait;
        conv_req_o ##1 (state_r == asb_pkg::ASB_WAIT);
    endsequence
    sequence s_done_push;
        conv_done_i ##1 (state_r == asb_pkg::ASB_PUSH);
    endsequence

    // completed sequences since the last interrupt, counted apart from the sequencer
    logic [4:0] seen_r, seen_nxt;
    always_comb begin
        seen_nxt = conv_irq_o ? 5'(seq_end) : 5'(seen_r + 5'(seq_end));
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            seen_r <= 5'h00;
        end else begin
            seen_r <= seen_nxt;
        end
    end

    ref_fixed_a: assert property (
        positive_reference_o == asb_pkg::ASB_REF_ANALOGUE_SUPPLY &&
        negative_reference_o == asb_pkg::ASB_REF_ANALOGUE_GROUND)
        else $error("reference pair not supply and ground");

    scan_select_a: assert property (
        conv_req_o && !use_sample_b_o |->
        chan_zero_sel_o == (scan_en ? scan_ptr_r : sample_a_ch_i))
        else $error("channel zero input selection wrong");

    scan_hold_a: assert property (
        seq_end && !scan_en |=> $stable(scan_ptr_r))
        else $error("scan pointer moved with scan off");

    chan_count_a: assert property (
        seq_end |-> ch_r == ((count_sel == 2'h0) ? 2'h0 : (count_sel == 2'h1) ? 2'h1 : 2'h3))
        else $error("sequence ended on wrong channel");

    req_flow_a: assert property (
        conv_req_o |-> s_req_wait)
        else $error("request did not lead to wait");

    done_push_a: assert property (
        (state_r == asb_pkg::ASB_WAIT) && conv_done_i |-> s_done_push)
        else $error("result did not lead to push");

    half_read_a: assert property (
        reg_re_i && sel_ctrl |=> reg_rdata_o[7] == $past(half_r))
        else $error("buffer half status misread");

    irq_rate_a: assert property (
        seq_end |=> conv_irq_o == (seen_r == 5'(rate_sel) + 5'h1))
        else $error("interrupt not at rate field plus one");

    split_toggle_a: assert property (
        conv_irq_o && $past(split_en) |-> half_r != $past(half_r) && idx_r[2:0] == 3'h0)
        else $error("split buffer did not swap halves");

    flat_restart_a: assert property (
        conv_irq_o && !$past(split_en) |-> idx_r == 4'h0 && !half_r)
        else $error("fill did not restart at zero");

    unused_zero_a: assert property (
        reg_re_i |=> reg_rdata_o[12:11] == 2'h0 && !reg_rdata_o[6])
        else $error("unimplemented bits read nonzero");

    write_store_a: assert property (
        reg_we_i && sel_ctrl |=> ctrl_r == ($past(reg_wdata_i) & `ASB_CTRL_WMASK))
        else $error("control write not stored");

    alt_toggle_a: assert property (
        seq_end && alt_en |=> alt_r != $past(alt_r))
        else $error("alternate sample did not toggle");
endmodule : asb_seq_ctrl
`default_nettype wire

// ==== verification/asb_seq_ctrl_tb.sv ====
// bench of the converter sequence control block: register port, sequencer, result stream
// assumes asb_cfg.svh and asb_pkg come first; the bench plays converter and consumer
`include "asb_cfg.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [3:0] addr; logic [15:0] wdata; logic [15:0] exp;} asb_reg_row_t;
    typedef struct {logic [1:0] cnt; logic [3:0] rate; logic split; logic alternate_sample_select; logic scan;
        int nseq;} asb_seq_row_t;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [3:0] reg_addr_i = 4'h0;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic reg_we_i = 1'b0;
    logic reg_re_i = 1'b0;
    logic trig_i = 1'b0;
    logic [15:0] scan_mask_i = 16'h0025;
    logic [3:0] sample_a_ch_i = 4'h3;
    logic [3:0] sample_b_ch_i = 4'h9;
    logic conv_done_i = 1'b0;
    logic [9:0] conv_data_i = 10'h000;
    logic res_ready_i = 1'b1;
    logic [15:0] reg_rdata_o;
    logic [15:0] res_data_o;
    asb_pkg::asb_ref_t positive_reference_o;
    asb_pkg::asb_ref_t negative_reference_o;
    logic conv_req_o;
    logic conv_irq_o;
    logic res_valid_o;
    logic use_sample_b_o;
    logic [1:0] conv_ch_o;
    logic [3:0] chan_zero_sel_o;
    int failures = 0;
    int compares = 0;
    int cyc = 0;
    int seq_k = 0;
    logic [15:0] exp_q[$];
    logic [15:0] got_q[$];
    logic [15:0] ctrl_w;
    logic [15:0] rd;
    logic [3:0] fill = 4'h0;
    logic half = 1'b0;
    // scan order for mask 0x0025: inputs 0, 2, 5, then around again
    logic [3:0] scan_tab [3] = '{4'h0, 4'h2, 4'h5};
    asb_reg_row_t reg_rows [5] = '{'{4'h0, 16'hffff, 16'he73f}, '{4'h0, 16'h18c0, 16'h0000},
        '{4'h0, 16'ha5a5, 16'ha525}, '{4'h5, 16'hffff, 16'ha525}, '{4'hf, 16'h0000, 16'ha525}};
    asb_seq_row_t seq_rows [9] = '{'{2'b00, 4'h0, 0, 0, 0, 2}, '{2'b01, 4'h1, 0, 0, 0, 3},
        '{2'b10, 4'h0, 0, 0, 0, 2}, '{2'b11, 4'h1, 0, 0, 0, 2}, '{2'b00, 4'he, 0, 0, 0, 15},
        '{2'b00, 4'hf, 0, 0, 0, 17}, '{2'b01, 4'h1, 1, 0, 0, 5}, '{2'b00, 4'h0, 0, 1, 0, 3},
        '{2'b00, 4'h0, 0, 0, 1, 4}};
    asb_seq_row_t fill_row = '{2'b11, 4'hf, 0, 0, 0, 5};

    asb_seq_ctrl uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
        .reg_rdata_o(reg_rdata_o), .trig_i(trig_i), .scan_mask_i(scan_mask_i),
        .sample_a_ch_i(sample_a_ch_i), .sample_b_ch_i(sample_b_ch_i),
        .positive_reference_o(positive_reference_o), .negative_reference_o(negative_reference_o),
        .conv_req_o(conv_req_o), .conv_ch_o(conv_ch_o), .chan_zero_sel_o(chan_zero_sel_o),
        .use_sample_b_o(use_sample_b_o), .conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
        .conv_irq_o(conv_irq_o), .res_valid_o(res_valid_o), .res_ready_i(res_ready_i),
        .res_data_o(res_data_o));

    ////////////////////////////////////////////////////////////
    // 25 ns clock
    always #12.5 clk_i = ~clk_i;

    // hang guard, far above the thousand or so cycles the run needs
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            failures++;
            $display("ERROR %0t: timeout", $time);
            complete_run();
        end
    end

    // consumer side: every accepted word is kept for comparison
    always @(posedge clk_i) begin
        if (res_valid_o === 1'b1 && res_ready_i === 1'b1) got_q.push_back(res_data_o);
    end

    ////////////////////////////////////////////////////////////
    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            failures++;
            $display("ERROR %0t: %s", $time, m);
        end
    endtask : chk

    task automatic complete_run();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    task automatic do_reset();
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        res_ready_i <= 1'b1;
        conv_done_i <= 1'b0;
        trig_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        chk(conv_req_o === 1'b0 && conv_irq_o === 1'b0 && res_valid_o === 1'b0
            && reg_rdata_o === 16'h0000, "outputs not idle in reset");
        reset_n_i <= 1'b1;
        exp_q.delete();
        got_q.delete();
        fill = 4'h0;
        half = 1'b0;
        seq_k = 0;
    endtask : do_reset

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_we_i <= 1'b1;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
    endtask : reg_wr

    // read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_re_i <= 1'b1;
        @(posedge clk_i);
        reg_re_i <= 1'b0;
        #1;
        d = reg_rdata_o;
        @(posedge clk_i);
        #1;
        chk(reg_rdata_o === 16'h0000, "read data held too long");
    endtask : reg_rd

    // checks the first look at once: the request may stand in the cycle we arrive in
    task automatic wait_req(output logic found);
        int n;
        n = 0;
        #1;
        found = (conv_req_o === 1'b1);
        while (!found && n < 30) begin
            @(posedge clk_i);
            #1;
            found = (conv_req_o === 1'b1);
            n++;
        end
    endtask : wait_req

    // one triggered sequence; stall holds the consumer off until the sequencer is seen to wait
    task automatic run_seq(input asb_seq_row_t r, input logic stall);
        int nch;
        logic found;
        logic irq;
        logic b;
        logic [3:0] sel;
        nch = (r.cnt == 2'b00) ? 1 : (r.cnt == 2'b01) ? 2 : 4;
        b = r.alternate_sample_select & seq_k[0];
        sel = r.scan ? scan_tab[seq_k % 3] : (b ? sample_b_ch_i : sample_a_ch_i);
        @(posedge clk_i);
        trig_i <= 1'b1;
        @(posedge clk_i);
        trig_i <= 1'b0;
        for (int c = 0; c < nch; c++) begin
            if (stall && c == 1) begin
                wait_req(found);
                chk(!found && res_valid_o === 1'b1, "sequencer ran on into a full fifo");
                @(posedge clk_i);
                res_ready_i <= 1'b1;
            end
            wait_req(found);
            chk(found && conv_ch_o === c[1:0], "channel order");
            if (c == 0) begin
                chk(chan_zero_sel_o === sel && use_sample_b_o === b, "selection");
            end
            @(posedge clk_i);
            conv_done_i <= 1'b1;
            conv_data_i <= 10'h2a5 ^ seq_k[9:0];
            exp_q.push_back({r.split ? {half, fill[2:0]} : fill, c[1:0], 10'h2a5 ^ seq_k[9:0]});
            fill = fill + 4'h1;
            @(posedge clk_i);
            conv_done_i <= 1'b0;
        end
        irq = 1'b0;
        repeat (4) begin
            @(posedge clk_i);
            #1;
            irq = irq | conv_irq_o;
        end
        seq_k++;
        chk(irq === ((seq_k % (r.rate + 1)) == 0), "interrupt rate");
        if ((seq_k % (r.rate + 1)) == 0) begin
            fill = 4'h0;
            half = half ^ r.split;
        end
        reg_rd(4'h0, rd);
        chk(rd === (ctrl_w | {8'h00, half, 7'h00}), "buffer half status");
    endtask : run_seq

    task automatic check_stream();
        repeat (8) @(posedge clk_i);
        chk(got_q.size() == exp_q.size() && res_valid_o === 1'b0, "stream word count");
        foreach (exp_q[j]) begin
            if (j < got_q.size()) chk(got_q[j] === exp_q[j], "result word");
        end
    endtask : check_stream

    ////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        reg_rd(4'h0, rd);
        chk(rd === 16'h0000, "control reset value");
        foreach (reg_rows[i]) begin
            reg_wr(reg_rows[i].addr, reg_rows[i].wdata);
            reg_rd(reg_rows[i].addr, rd);
            chk(rd === (|reg_rows[i].addr ? 16'h0000 : reg_rows[i].exp), "readback");
            reg_rd(4'h0, rd);
            chk(rd === reg_rows[i].exp, "control word");
            chk(positive_reference_o === asb_pkg::ASB_REF_ANALOGUE_SUPPLY
                && negative_reference_o === asb_pkg::ASB_REF_ANALOGUE_GROUND, "reference");
        end
        $display("test registers done");
        foreach (seq_rows[i]) begin
            do_reset();
            ctrl_w = {3'h5, 2'b00, seq_rows[i].scan, seq_rows[i].cnt, 2'b00, seq_rows[i].rate,
                seq_rows[i].split, seq_rows[i].alternate_sample_select};
            reg_wr(4'h0, ctrl_w);
            repeat (seq_rows[i].nseq) run_seq(seq_rows[i], 1'b0);
            check_stream();
            $display("test sequence row %0d done", i);
        end
        // fill the fifo with the consumer stalled, then drain it empty
        do_reset();
        ctrl_w = 16'h033c;
        reg_wr(4'h0, ctrl_w);
        res_ready_i <= 1'b0;
        repeat (4) run_seq(fill_row, 1'b0);
        run_seq(fill_row, 1'b1);
        check_stream();
        $display("test fifo fill done");
        // reset in mid-sequence must leave the register at its reset value
        @(posedge clk_i);
        trig_i <= 1'b1;
        do_reset();
        reg_rd(4'h0, rd);
        chk(rd === 16'h0000, "control after reset mid-run");
        $display("test mid-run reset done");
        complete_run();
    end
endmodule : tb
`default_nettype wire
